// ==== srhp_regs.svh ====
// Register indices, reset values and protocol constants of the serial register port
`ifndef SRHP_REGS_SVH
`define SRHP_REGS_SVH

`define SRHP_IDX_DETECT_FLAGS 8'h00
`define SRHP_IDX_CONTROL_A 8'h01
`define SRHP_IDX_CONTROL_B 8'h02
`define SRHP_IDX_CONTROL_C 8'h03
`define SRHP_IDX_CONTROL_D 8'h04
`define SRHP_IDX_HACTIVE_BEGIN_LOW 8'h05
`define SRHP_IDX_HACTIVE_END_LOW 8'h06
`define SRHP_IDX_HSYNC_ONE_BEGIN 8'h07
`define SRHP_IDX_HSYNC_ONE_END 8'h08
`define SRHP_IDX_HSYNC_TWO_BEGIN 8'h09
`define SRHP_IDX_HSYNC_TWO_END 8'h0a
`define SRHP_IDX_GAIN_CONTROL_LEVEL 8'h0b
`define SRHP_IDX_HORIZ_TIMING_HIGH_BITS 8'h0c
`define SRHP_IDX_COLOR_DECODE_CTRL 8'h0d
`define SRHP_IDX_GENERAL_PURPOSE_PORTS 8'h0e
`define SRHP_IDX_LUMINANCE_CTRL 8'h0f
`define SRHP_IDX_LUMINANCE_GAIN 8'h10
`define SRHP_IDX_BRIGHTNESS_OFFSET 8'h11
`define SRHP_IDX_COLOR_CTRL_A 8'h12
`define SRHP_IDX_COLOR_CTRL_B 8'h13
`define SRHP_IDX_SUBCARRIER_DECODE_CTRL 8'h14
`define SRHP_IDX_COLOR_INTENSITY 8'h15
`define SRHP_IDX_HUE_ADJUST 8'h16
`define SRHP_IDX_VERTICAL_FILTER_A 8'h17
`define SRHP_IDX_VERTICAL_FILTER_B 8'h18
`define SRHP_IDX_VERTICAL_FILTER_C 8'h19
`define SRHP_IDX_HORIZ_SCALE_LOW 8'h1a
`define SRHP_IDX_HORIZ_SCALE_HIGH 8'h1b
`define SRHP_IDX_VERT_SCALE_LOW 8'h1c
`define SRHP_IDX_VERT_SCALE_HIGH 8'h1d
`define SRHP_IDX_OUTPUT_FORMAT_A 8'h1e
`define SRHP_IDX_OUTPUT_FORMAT_B 8'h1f

`define SRHP_RST_CONTROL_A 8'h2c
`define SRHP_RST_CONTROL_B 8'h20
`define SRHP_RST_GAIN_CONTROL_LEVEL 8'h50
`define SRHP_RST_COLOR_CTRL_A 8'h08
`define SRHP_RST_VERTICAL_FILTER_C 8'h03
`define SRHP_RST_VERT_SCALE_LOW 8'hfc
`define SRHP_RST_VERT_SCALE_HIGH 8'hff
`define SRHP_RST_OUTPUT_FORMAT_A 8'h00
`define SRHP_RST_OTHER 8'h00

`define SRHP_GAMMA_FIRST 8'h40
`define SRHP_READ_UNMAPPED 8'h00
`define SRHP_LAST_DATA_BIT 4'h7
`define SRHP_ACK_SLOT 4'h8
`define SRHP_ID_BASE_RESET 5'h10

`endif

// ==== srhp_pkg.sv ====
// Types shared by the serial register port
package srhp_pkg;

	typedef enum logic [5:0] {
		SRHP_IDLE = 6'h01,
		SRHP_ID = 6'h02,
		SRHP_INDEX = 6'h04,
		SRHP_WRITE = 6'h08,
		SRHP_READ = 6'h10,
		SRHP_SKIP = 6'h20
	} srhp_state_type;

	typedef logic [31:1][7:0] srhp_ctrl_type;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} srhp_gamma_type;

endpackage

// ==== srhp_serial_register_host_port.sv ====
// Two-wire serial slave port holding the decoder control registers
//
// Function
// - Bytes travel most significant bit first and each bit is taken while the serial clock is high.
// - Two strap pins pick one of four slave addresses.
// - The index advances by one after each data byte written.
// - A byte takes nine serial clocks, eight data bits and one acknowledge.
// - The port pulls the data line low in the ninth clock of each received byte, except an identifier not its own and later bytes until START or STOP.
// - The second read phase sends the identifier with direction one and the port drives data.
// - The index also advances after each byte read.
// - Gamma table locations are write only and read back as zero.
// - While the index lies in 0x40 to 0xff the gamma table is held in programming mode.
// - Every control register takes its listed default at reset.
`timescale 1ns/1ps
`include "srhp_regs.svh"

module srhp_serial_register_host_port #(
	parameter logic [4:0] ID_HIGH_BITS = `SRHP_ID_BASE_RESET
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_clock,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe,
	input wire logic addr_select_hi_pin,
	input wire logic addr_select_lo_pin,
	input wire logic [7:0] detect_flags,
	output srhp_pkg::srhp_ctrl_type ctrl_regs,
	output logic gamma_prog_mode,
	output srhp_pkg::srhp_gamma_type gamma_write
);

	// Link domain: bits shift in on the rising serial clock
	logic [7:0] link_shift_reg;
	logic [7:0] link_shift_next;

	always_comb begin
		link_shift_next = {link_shift_reg[6:0], serial_data_line_in};
	end

	// No reset: the word is only read once a whole byte has shifted in
	always_ff @(posedge serial_clock) begin
		link_shift_reg <= link_shift_next;
	end

	// Pin synchronisers: serial clock, data, two straps
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_meta_next;
	logic [3:0] pin_sync_reg;
	logic [3:0] pin_sync_next;
	logic [1:0] pin_prev_reg;
	logic [1:0] pin_prev_next;
	logic rise_late_reg;
	logic rise_late_next;
	logic scl_s;
	logic sda_s;
	logic scl_p;
	logic sda_p;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [6:0] slave_id;

	always_comb begin
		pin_meta_next = {serial_clock, serial_data_line_in, addr_select_hi_pin,
			addr_select_lo_pin};
		pin_sync_next = pin_meta_reg;
		pin_prev_next = pin_sync_reg[3:2];
		rise_late_next = scl_rise;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_reg <= 4'hc;
			pin_sync_reg <= 4'hc;
			pin_prev_reg <= 2'h3;
			rise_late_reg <= 1'b0;
		end else begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
			pin_prev_reg <= pin_prev_next;
			rise_late_reg <= rise_late_next;
		end
	end

	assign scl_s = pin_sync_reg[3];
	assign sda_s = pin_sync_reg[2];
	assign scl_p = pin_prev_reg[1];
	assign sda_p = pin_prev_reg[0];
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

	// Strap address held in a register so a moving strap cannot split an identifier compare
	logic [6:0] id_reg;
	logic [6:0] id_next;

	always_comb begin
		id_next = {ID_HIGH_BITS, pin_sync_reg[1:0]};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			id_reg <= {ID_HIGH_BITS, 2'h0};
		end else begin
			id_reg <= id_next;
		end
	end

	assign slave_id = id_reg;

	// Transfer engine
	srhp_pkg::srhp_state_type state_reg;
	srhp_pkg::srhp_state_type state_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [7:0] index_reg;
	logic [7:0] index_next;
	logic ack_reg;
	logic ack_next;
	logic dir_read_reg;
	logic dir_read_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic oe_reg;
	logic oe_next;
	srhp_pkg::srhp_gamma_type gamma_reg;
	srhp_pkg::srhp_gamma_type gamma_next;
	logic reg_we;
	logic [7:0] rd_value;
	logic [7:0] rx_byte;
	srhp_pkg::srhp_ctrl_type regs_reg;

	// Byte is sampled a cycle after the synchronised rise so the link word has settled
	assign rx_byte = link_shift_reg;

	always_comb begin
		rd_value = `SRHP_READ_UNMAPPED;
		if (index_reg == `SRHP_IDX_DETECT_FLAGS) begin
			// Status flags come straight from the decoder core
			rd_value = detect_flags;
		end else if (index_reg <= `SRHP_IDX_OUTPUT_FORMAT_B) begin
			rd_value = regs_reg[index_reg[4:0]];
		end else if (index_reg < `SRHP_GAMMA_FIRST) begin
			// Indices past the control block are not held by this port
			rd_value = `SRHP_READ_UNMAPPED;
		end else begin
			rd_value = `SRHP_READ_UNMAPPED;
		end
	end

	// Read word registered so the shift-out path starts from a flip-flop
	logic [7:0] rd_word_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_word_reg <= `SRHP_READ_UNMAPPED;
		end else begin
			rd_word_reg <= rd_value;
		end
	end

	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		index_next = index_reg;
		ack_next = ack_reg;
		dir_read_next = dir_read_reg;
		tx_next = tx_reg;
		oe_next = oe_reg;
		gamma_next = gamma_reg;
		gamma_next.wr = 1'b0;
		reg_we = 1'b0;
		if (start_det) begin
			// A repeated START restarts the byte engine from the identifier
			state_next = srhp_pkg::SRHP_ID;
			bit_cnt_next = 4'h0;
			ack_next = 1'b0;
			oe_next = 1'b0;
		end else if (stop_det) begin
			state_next = srhp_pkg::SRHP_IDLE;
			bit_cnt_next = 4'h0;
			ack_next = 1'b0;
			oe_next = 1'b0;
		end else if (rise_late_reg && state_reg != srhp_pkg::SRHP_IDLE) begin
			if (bit_cnt_reg != `SRHP_ACK_SLOT) begin
				bit_cnt_next = bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == `SRHP_LAST_DATA_BIT) begin
					unique case (state_reg)
						srhp_pkg::SRHP_ID: begin
							if (rx_byte[7:1] == slave_id) begin
								ack_next = 1'b1;
								dir_read_next = rx_byte[0];
							end else begin
								state_next = srhp_pkg::SRHP_SKIP;
							end
						end
						srhp_pkg::SRHP_INDEX: begin
							index_next = rx_byte;
							ack_next = 1'b1;
						end
						srhp_pkg::SRHP_WRITE: begin
							ack_next = 1'b1;
							index_next = index_reg + 8'h01;
							reg_we = (index_reg != `SRHP_IDX_DETECT_FLAGS) &&
								(index_reg <= `SRHP_IDX_OUTPUT_FORMAT_B);
							gamma_next.wr = (index_reg >= `SRHP_GAMMA_FIRST);
							gamma_next.addr = index_reg;
							gamma_next.data = rx_byte;
						end
						default: begin
						end
					endcase
				end
			end else begin
				bit_cnt_next = 4'h0;
				ack_next = 1'b0;
				unique case (state_reg)
					srhp_pkg::SRHP_ID: begin
						state_next = dir_read_reg ? srhp_pkg::SRHP_READ :
							srhp_pkg::SRHP_INDEX;
					end
					srhp_pkg::SRHP_INDEX: begin
						state_next = srhp_pkg::SRHP_WRITE;
					end
					srhp_pkg::SRHP_READ: begin
						// Host refusal ends the read until the next START or STOP
						if (sda_s) begin
							state_next = srhp_pkg::SRHP_SKIP;
						end
					end
					default: begin
					end
				endcase
			end
		end else if (scl_fall && state_reg != srhp_pkg::SRHP_IDLE) begin
			if (bit_cnt_reg == `SRHP_ACK_SLOT) begin
				oe_next = ack_reg;
			end else if (state_reg == srhp_pkg::SRHP_READ) begin
				// Only a zero bit pulls the line; a one bit is left to the pull-up
				if (bit_cnt_reg == 4'h0) begin
					// Index moves on as each byte is loaded, so a refused last byte still advances
					oe_next = ~rd_word_reg[7];
					tx_next = {rd_word_reg[6:0], 1'b0};
					index_next = index_reg + 8'h01;
				end else begin
					oe_next = ~tx_reg[7];
					tx_next = {tx_reg[6:0], 1'b0};
				end
			end else begin
				oe_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= srhp_pkg::SRHP_IDLE;
			bit_cnt_reg <= 4'h0;
			index_reg <= `SRHP_IDX_DETECT_FLAGS;
			ack_reg <= 1'b0;
			dir_read_reg <= 1'b0;
			tx_reg <= 8'h00;
			oe_reg <= 1'b0;
			gamma_reg <= '0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			index_reg <= index_next;
			ack_reg <= ack_next;
			dir_read_reg <= dir_read_next;
			tx_reg <= tx_next;
			oe_reg <= oe_next;
			gamma_reg <= gamma_next;
		end
	end

	// Control registers with their power-up defaults; unlisted indices come up as zero
	function automatic logic [7:0] srhp_reset_value(input logic [4:0] idx);
		logic [7:0] val;
		val = `SRHP_RST_OTHER;
		unique case ({3'h0, idx})
			`SRHP_IDX_CONTROL_A: val = `SRHP_RST_CONTROL_A;
			`SRHP_IDX_CONTROL_B: val = `SRHP_RST_CONTROL_B;
			`SRHP_IDX_CONTROL_C: val = `SRHP_RST_OTHER;
			`SRHP_IDX_CONTROL_D: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HACTIVE_BEGIN_LOW: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HACTIVE_END_LOW: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HSYNC_ONE_BEGIN: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HSYNC_ONE_END: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HSYNC_TWO_BEGIN: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HSYNC_TWO_END: val = `SRHP_RST_OTHER;
			`SRHP_IDX_GAIN_CONTROL_LEVEL: val = `SRHP_RST_GAIN_CONTROL_LEVEL;
			`SRHP_IDX_HORIZ_TIMING_HIGH_BITS: val = `SRHP_RST_OTHER;
			`SRHP_IDX_COLOR_DECODE_CTRL: val = `SRHP_RST_OTHER;
			`SRHP_IDX_GENERAL_PURPOSE_PORTS: val = `SRHP_RST_OTHER;
			`SRHP_IDX_LUMINANCE_CTRL: val = `SRHP_RST_OTHER;
			`SRHP_IDX_LUMINANCE_GAIN: val = `SRHP_RST_OTHER;
			`SRHP_IDX_BRIGHTNESS_OFFSET: val = `SRHP_RST_OTHER;
			`SRHP_IDX_COLOR_CTRL_A: val = `SRHP_RST_COLOR_CTRL_A;
			`SRHP_IDX_COLOR_CTRL_B: val = `SRHP_RST_OTHER;
			`SRHP_IDX_SUBCARRIER_DECODE_CTRL: val = `SRHP_RST_OTHER;
			`SRHP_IDX_COLOR_INTENSITY: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HUE_ADJUST: val = `SRHP_RST_OTHER;
			`SRHP_IDX_VERTICAL_FILTER_A: val = `SRHP_RST_OTHER;
			`SRHP_IDX_VERTICAL_FILTER_B: val = `SRHP_RST_OTHER;
			`SRHP_IDX_VERTICAL_FILTER_C: val = `SRHP_RST_VERTICAL_FILTER_C;
			`SRHP_IDX_HORIZ_SCALE_LOW: val = `SRHP_RST_OTHER;
			`SRHP_IDX_HORIZ_SCALE_HIGH: val = `SRHP_RST_OTHER;
			`SRHP_IDX_VERT_SCALE_LOW: val = `SRHP_RST_VERT_SCALE_LOW;
			`SRHP_IDX_VERT_SCALE_HIGH: val = `SRHP_RST_VERT_SCALE_HIGH;
			`SRHP_IDX_OUTPUT_FORMAT_A: val = `SRHP_RST_OUTPUT_FORMAT_A;
			`SRHP_IDX_OUTPUT_FORMAT_B: val = `SRHP_RST_OTHER;
			default: val = `SRHP_RST_OTHER;
		endcase
		return val;
	endfunction

	// Index 0x00 is status and has no storage here
	genvar gi;
	generate
		for (gi = 1; gi < 32; gi = gi + 1) begin : g_ctrl
			logic [7:0] ctrl_next;

			always_comb begin
				ctrl_next = regs_reg[gi];
				if (reg_we && index_reg[4:0] == 5'(gi)) begin
					ctrl_next = rx_byte;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					regs_reg[gi] <= srhp_reset_value(5'(gi));
				end else begin
					regs_reg[gi] <= ctrl_next;
				end
			end
		end
	endgenerate

	// Table program mode follows the index one clock later
	logic prog_mode_reg;
	logic prog_mode_next;

	always_comb begin
		prog_mode_next = (index_reg >= `SRHP_GAMMA_FIRST);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prog_mode_reg <= 1'b0;
		end else begin
			prog_mode_reg <= prog_mode_next;
		end
	end

	// Open-drain data line: only ever pulled low
	assign serial_data_line_out = 1'b0;
	assign serial_data_line_oe = oe_reg;
	assign ctrl_regs = regs_reg;
	assign gamma_prog_mode = prog_mode_reg;
	assign gamma_write = gamma_reg;

endmodule

// ==== srhp_serial_register_host_port_assertions.sv ====
// Port checker for the serial register port
`timescale 1ns/1ps
module srhp_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_clock,
	input wire logic serial_data_line_in,
	input wire logic serial_data_line_out,
	input wire logic serial_data_line_oe,
	input wire logic addr_select_hi_pin,
	input wire logic addr_select_lo_pin,
	input wire logic [7:0] detect_flags,
	input wire srhp_pkg::srhp_ctrl_type ctrl_regs,
	input wire logic gamma_prog_mode,
	input wire srhp_pkg::srhp_gamma_type gamma_write
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_OPEN_DRAIN: assert property (serial_data_line_out == 1'b0)
		else $error("data line driven high");
	AST_RESET_DEFAULTS: assert property (disable iff (1'b0) rst |=> ctrl_regs[1] == 8'h2c
		&& ctrl_regs[2] == 8'h20 && ctrl_regs[11] == 8'h50) else $error("bad defaults");
	AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> !serial_data_line_oe
		&& !gamma_prog_mode && !gamma_write.wr) else $error("not idle in reset");
	AST_OE_MOVES_LOW: assert property (!$stable(serial_data_line_oe) |-> !serial_clock)
		else $error("data line moved while clock high");
	AST_OE_HOLDS: assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe[*8])
		else $error("drive too short");
	AST_CTRL_ON_HIGH: assert property (!$stable(ctrl_regs) |-> serial_clock)
		else $error("register changed outside a bit");
	AST_PULSE_ONE: assert property (gamma_write.wr |=> !gamma_write.wr)
		else $error("table write pulse too long");
	AST_PULSE_RANGE: assert property (gamma_write.wr |-> gamma_write.addr >= 8'h40)
		else $error("table write outside range");
endmodule
bind srhp_serial_register_host_port srhp_checker i_srhp_checker (.clk(clk), .rst(rst),
	.serial_clock(serial_clock), .serial_data_line_in(serial_data_line_in),
	.serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
	.addr_select_hi_pin(addr_select_hi_pin), .addr_select_lo_pin(addr_select_lo_pin),
	.detect_flags(detect_flags), .ctrl_regs(ctrl_regs), .gamma_prog_mode(gamma_prog_mode),
	.gamma_write(gamma_write));

// ==== srhp_host_model.sv ====
// Two-wire bus master model
`timescale 1ns/1ps
module srhp_host_model #(
	parameter int HALF_NS = 22
) (
	output logic serial_clock,
	output logic host_pull,
	input wire logic serial_data_line
);
	initial begin
		serial_clock = 1'b1;
		host_pull = 1'b0;
	end
	task automatic cycle_bit(input logic b, output logic r);
		host_pull = !b;
		#HALF_NS;
		serial_clock = 1'b1;
		#(HALF_NS / 2);
		r = serial_data_line;
		#(HALF_NS / 2);
		serial_clock = 1'b0;
		#4;
	endtask
	task automatic start_cond;
		host_pull = 1'b0;
		#HALF_NS;
		serial_clock = 1'b1;
		#HALF_NS;
		host_pull = 1'b1;
		#HALF_NS;
		serial_clock = 1'b0;
		#4;
	endtask
	task automatic stop_cond;
		host_pull = 1'b1;
		#HALF_NS;
		serial_clock = 1'b1;
		#HALF_NS;
		host_pull = 1'b0;
		#HALF_NS;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic acked);
		logic r;
		for (int i = 7; i >= 0; i--) cycle_bit(d[i], r);
		cycle_bit(1'b1, r);
		acked = !r;
	endtask
	task automatic get_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) cycle_bit(1'b1, d[i]);
		cycle_bit(!more, r);
	endtask
endmodule

// ==== srhp_serial_register_host_port_test.sv ====
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module srhp_serial_register_host_port_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel_hi = 1'b1;
	logic sel_lo = 1'b0;
	logic [7:0] flags = 8'h96;
	logic scl;
	logic pull;
	logic sda_out;
	logic sda_oe;
	logic sda;
	logic gmode;
	srhp_pkg::srhp_ctrl_type ctrl;
	srhp_pkg::srhp_gamma_type gw;
	logic [7:0] g_addr;
	logic [7:0] g_data;
	logic [6:0] dev_id = 7'h42;
	int errors = 0;
	int num_checks = 0;
	always #2 clk = ~clk;
	// Pull-up: released line reads high
	assign sda = !(pull || (sda_oe && !sda_out));
	always @(posedge clk) if (gw.wr === 1'b1) begin
		g_addr <= gw.addr;
		g_data <= gw.data;
	end
	srhp_serial_register_host_port i_srhp_serial_register_host_port (.clk(clk), .rst(rst),
		.serial_clock(scl), .serial_data_line_in(sda), .serial_data_line_out(sda_out),
		.serial_data_line_oe(sda_oe), .addr_select_hi_pin(sel_hi), .addr_select_lo_pin(sel_lo),
		.detect_flags(flags), .ctrl_regs(ctrl), .gamma_prog_mode(gmode), .gamma_write(gw));
	srhp_host_model i_srhp_host_model (.serial_clock(scl), .host_pull(pull),
		.serial_data_line(sda));
	task automatic finish_test;
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] d);
		logic a;
		i_srhp_host_model.put_byte(d, a);
		chk({7'h00, a}, 8'h01);
	endtask
	task automatic open_write(input logic [7:0] idx);
		i_srhp_host_model.start_cond();
		send({dev_id, 1'b0});
		send(idx);
	endtask
	task automatic read_two(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] d;
		open_write(idx);
		i_srhp_host_model.stop_cond();
		i_srhp_host_model.start_cond();
		send({dev_id, 1'b1});
		i_srhp_host_model.get_byte(1'b1, d);
		chk(d, e0);
		i_srhp_host_model.get_byte(1'b0, d);
		chk(d, e1);
		i_srhp_host_model.stop_cond();
	endtask
	task automatic test_defaults;
		logic [7:0] idx [8] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h12, 8'h19, 8'h1c, 8'h1d};
		logic [7:0] val [8] = '{8'h2c, 8'h20, 8'h00, 8'h50, 8'h08, 8'h03, 8'hfc, 8'hff};
		for (int i = 0; i < 8; i++) chk(ctrl[idx[i]], val[i]);
		chk({7'h00, gmode}, 8'h00);
		read_two(8'h00, 8'h96, 8'h2c);
	endtask
	task automatic test_burst;
		open_write(8'h1e);
		send(8'ha5);
		send(8'h5a);
		send(8'h3c);
		open_write(8'h03);
		send(8'hc3);
		i_srhp_host_model.stop_cond();
		chk(ctrl[30], 8'ha5);
		chk(ctrl[31], 8'h5a);
		chk(ctrl[3], 8'hc3);
		read_two(8'h1e, 8'ha5, 8'h5a);
	endtask
	task automatic test_strap;
		logic a;
		i_srhp_host_model.start_cond();
		i_srhp_host_model.put_byte({7'h41, 1'b0}, a);
		chk({7'h00, a}, 8'h00);
		i_srhp_host_model.stop_cond();
		@(posedge clk);
		sel_hi <= 1'b0;
		sel_lo <= 1'b1;
		dev_id = 7'h41;
		repeat (4) @(posedge clk);
		open_write(8'h10);
		send(8'h77);
		i_srhp_host_model.stop_cond();
		chk(ctrl[16], 8'h77);
	endtask
	task automatic test_gamma;
		open_write(8'hfe);
		chk({7'h00, gmode}, 8'h01);
		send(8'h11);
		send(8'h22);
		chk({7'h00, gmode}, 8'h00);
		i_srhp_host_model.stop_cond();
		chk(g_addr, 8'hff);
		chk(g_data, 8'h22);
		read_two(8'h40, 8'h00, 8'h00);
		chk({7'h00, gmode}, 8'h01);
		open_write(8'h05);
		i_srhp_host_model.stop_cond();
		chk({7'h00, gmode}, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_defaults();
		test_burst();
		test_strap();
		test_gamma();
		finish_test();
	end
	initial begin
		#300000;
		errors++;
		finish_test();
	end
endmodule
